// ### hbridge_ctrl.sv
// Control, protection and register logic of the H-bridge driver.
//
// Register access over AXI4-Lite and the register offsets were chosen for this implementation.
`default_nettype none
`include "hbridge_cfg.svh"
module hbridge_ctrl (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic polarity_in_a,
    input wire logic polarity_in_b,
    input wire logic primary_disable,
    input wire logic enable_or_secondary_disable,
    input wire logic fault_flag_n_in,
    input wire logic limit_trip,
    input wire logic foldback_trip,
    input wire logic short_detect,
    input wire logic temp_hot,
    input wire logic temp_over,
    input wire logic temp_below_hyst,
    input wire logic undervoltage,
    output logic bridge_out_a,
    output logic bridge_out_a_oe,
    output logic bridge_out_b,
    output logic bridge_out_b_oe,
    output logic fault_flag_n_out,
    output logic fault_flag_n_oe,
    output logic sleep_mode,
    output logic irq,
    input wire logic [`ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    hbridge_pkg::pins_t pins_raw, pins_s1_q, pins_q, pins_prev_q;
    hbridge_pkg::sense_t sense_raw, sense_s1_q, sense_q;

    assign pins_raw = '{pol_a: polarity_in_a, pol_b: polarity_in_b,
                        dis: primary_disable, en: enable_or_secondary_disable,
                        flag_pin: fault_flag_n_in};
    assign sense_raw = '{lim_trip: limit_trip, fold_trip: foldback_trip,
                         short_det: short_detect, hot: temp_hot,
                         overtemp: temp_over, below_hyst: temp_below_hyst,
                         uv: undervoltage};

    // Enable resets low so the part starts asleep, as its pull-down would hold it.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pins_s1_q <= '0;
            pins_q <= '0;
            pins_prev_q <= '0;
        end else begin
            pins_s1_q <= pins_raw;
            pins_q <= pins_s1_q;
            pins_prev_q <= pins_q;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sense_s1_q <= '0;
            sense_q <= '0;
        end else begin
            sense_s1_q <= sense_raw;
            sense_q <= sense_s1_q;
        end
    end

    // ****************************************************************
    // Fault latches
    // ****************************************************************
    logic dis_fall, en_rise, short_q, ot_q, short_d, ot_d, sw_disable_q;
    hbridge_pkg::bridge_state_t state_q, state_d;

    assign dis_fall = pins_prev_q.dis & ~pins_q.dis;
    assign en_rise = ~pins_prev_q.en & pins_q.en;

    // Detection sets the latch only in drive, so a detection in the clearing cycle is dropped.
    always_comb begin
        short_d = short_q;
        if (dis_fall || en_rise) begin
            short_d = 1'b0;
        end
        if (sense_q.short_det && state_q == hbridge_pkg::ST_DRIVE) begin
            short_d = 1'b1;
        end
    end

    // Enable rising clears once below the trip; disable falling needs the hysteresis point.
    always_comb begin
        ot_d = ot_q;
        if ((en_rise && !sense_q.overtemp) || (dis_fall && sense_q.below_hyst)) begin
            ot_d = 1'b0;
        end
        if (sense_q.overtemp && pins_q.en) begin
            ot_d = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            short_q <= 1'b0;
            ot_q <= 1'b0;
        end else begin
            short_q <= short_d;
            ot_q <= ot_d;
        end
    end

    // ****************************************************************
    // Bridge state and timers
    // ****************************************************************
    logic drive_ok, trip, blank_busy, blank_start, off_busy, off_start, out_a_q, out_b_q, oe_q;

    // Undervoltage is not latched: the bridge returns on its own when it clears.
    assign drive_ok = ~pins_q.dis & ~sense_q.uv & ~short_d & ~ot_d & ~sw_disable_q;
    assign trip = sense_q.hot ? sense_q.fold_trip : sense_q.lim_trip;

    always_comb begin
        state_d = state_q;
        if (!pins_q.en) begin
            state_d = hbridge_pkg::ST_SLEEP;
        end else if (!drive_ok) begin
            state_d = hbridge_pkg::ST_HOLD;
        end else begin
            case (state_q)
                hbridge_pkg::ST_DRIVE: begin
                    if (trip && !blank_busy) begin
                        state_d = hbridge_pkg::ST_CHOP;
                    end
                end
                hbridge_pkg::ST_CHOP: begin
                    if (!off_busy) begin
                        state_d = hbridge_pkg::ST_DRIVE;
                    end
                end
                default: begin
                    state_d = hbridge_pkg::ST_DRIVE;
                end
            endcase
        end
    end

    assign off_start = (state_d == hbridge_pkg::ST_CHOP) && (state_q != hbridge_pkg::ST_CHOP);
    // Blanking restarts on each level change and each return to drive.
    assign blank_start = (state_d == hbridge_pkg::ST_DRIVE)
                         && ((state_q != hbridge_pkg::ST_DRIVE) || (pins_q.pol_a != out_a_q)
                             || (pins_q.pol_b != out_b_q));

    hb_interval_timer #(.W(`TIMER_W)) u_blank (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .start(blank_start),
        .load(`TIMER_W'(`TBLANK_CYC)),
        .busy(blank_busy)
    );

    hb_interval_timer #(.W(`TIMER_W)) u_off (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .start(off_start),
        .load(`TIMER_W'(`TOFF_CYC)),
        .busy(off_busy)
    );

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= hbridge_pkg::ST_SLEEP;
        end else begin
            state_q <= state_d;
        end
    end

    // Levels track the inputs while tri-stated, so re-enabling drives fresh values.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            out_a_q <= 1'b0;
            out_b_q <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            out_a_q <= pins_q.pol_a;
            out_b_q <= pins_q.pol_b;
            oe_q <= (state_d == hbridge_pkg::ST_DRIVE);
        end
    end

    assign bridge_out_a = out_a_q;
    assign bridge_out_b = out_b_q;
    assign bridge_out_a_oe = oe_q;
    assign bridge_out_b_oe = oe_q;

    // ****************************************************************
    // Fault flag and sleep
    // ****************************************************************
    logic flag_q, sleep_q;

    // The flag is quiet in sleep, even with a latch pending.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            flag_q <= 1'b0;
            sleep_q <= 1'b1;
        end else begin
            flag_q <= pins_q.en & (pins_q.dis | sense_q.uv | short_d | ot_d);
            sleep_q <= ~pins_q.en;
        end
    end

    assign fault_flag_n_out = 1'b0;
    assign fault_flag_n_oe = flag_q;
    assign sleep_mode = sleep_q;

    // ****************************************************************
    // Event status and interrupt
    // ****************************************************************
    hbridge_pkg::events_t evt, status_q, status_d, mask_q, status_clr;
    logic uv_prev_q, hot_prev_q, irq_q;

    assign evt = '{hot_entry: sense_q.hot & ~hot_prev_q,
                   chop: off_start,
                   uv: sense_q.uv & ~uv_prev_q,
                   overtemp: ot_d & ~ot_q,
                   short_ckt: short_d & ~short_q};

    // Events arriving during the clearing read survive it.
    assign status_d = (status_q & ~status_clr) | evt;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            status_q <= '0;
            uv_prev_q <= 1'b0;
            hot_prev_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            status_q <= status_d;
            uv_prev_q <= sense_q.uv;
            hot_prev_q <= sense_q.hot;
            irq_q <= |(status_d & mask_q);
        end
    end

    assign irq = irq_q;

    // ****************************************************************
    // AXI4-Lite write channel
    // ****************************************************************
    logic awready_q, wready_q, bvalid_q, do_write;
    logic [1:0] bresp_q;
    logic [`ADDR_W-1:0] waddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;

    assign do_write = ~awready_q & ~wready_q & ~bvalid_q;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            bvalid_q <= 1'b0;
            bresp_q <= `RESP_OKAY;
            waddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else begin
            if (s_axi_awvalid && awready_q) begin
                awready_q <= 1'b0;
                waddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && wready_q) begin
                wready_q <= 1'b0;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_write) begin
                bvalid_q <= 1'b1;
                bresp_q <= (waddr_q == `OFS_CTRL || waddr_q == `OFS_MASK
                            || waddr_q == `OFS_STATUS || waddr_q == `OFS_STATE)
                           ? `RESP_OKAY : `RESP_SLVERR;
            end
            if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
                awready_q <= 1'b1;
                wready_q <= 1'b1;
            end
        end
    end

    // Status and state are read-only; writes there are accepted and dropped.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sw_disable_q <= `CTRL_RST;
            mask_q <= `MASK_RST;
        end else if (do_write && wstrb_q[0]) begin
            if (waddr_q == `OFS_CTRL) begin
                sw_disable_q <= wdata_q[0];
            end
            if (waddr_q == `OFS_MASK) begin
                mask_q <= wdata_q[`EVT_W-1:0];
            end
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    // ****************************************************************
    // AXI4-Lite read channel
    // ****************************************************************
    logic arready_q, rvalid_q, rd_take;
    logic [1:0] rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;

    assign rd_take = s_axi_arvalid & arready_q;
    assign status_clr = (rd_take && s_axi_araddr == `OFS_STATUS) ? status_q : '0;

    always_comb begin
        rdata_d = '0;
        rresp_d = `RESP_OKAY;
        case (s_axi_araddr)
            `OFS_CTRL: rdata_d[0] = sw_disable_q;
            `OFS_STATUS: rdata_d[`EVT_W-1:0] = status_q;
            `OFS_MASK: rdata_d[`EVT_W-1:0] = mask_q;
            `OFS_STATE: rdata_d[11:0] = {pins_q.flag_pin, sense_q.hot, sense_q.uv,
                                         ot_q, short_q, flag_q, sleep_q, out_b_q,
                                         out_a_q, oe_q, state_q};
            default: rresp_d = `RESP_SLVERR;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rresp_q <= `RESP_OKAY;
            rdata_q <= '0;
        end else begin
            if (rd_take) begin
                arready_q <= 1'b0;
                rvalid_q <= 1'b1;
                rdata_q <= rdata_d;
                rresp_q <= rresp_d;
            end
            if (rvalid_q && s_axi_rready) begin
                rvalid_q <= 1'b0;
                arready_q <= 1'b1;
            end
        end
    end

    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;
endmodule // hbridge_ctrl
`default_nettype wire

// ### hbridge_cfg.svh
// Constants for the H-bridge control and fault logic.
// Behaviour
// - Each polarity input sets its own half-bridge level.
// - Primary disable high tri-states both outputs and raises the flag.
// - Enable low tri-states both outputs at once.
// - Enable low puts the device to sleep.
// - Enable high means outputs follow the inputs.
// - Undriven enable defaults low, device asleep.
// - Fault flag holds until a disable toggles.
// - Short circuit latches both outputs off.
// - Current limit trip chops with fixed off time.
// - Hot die selects the lower trip threshold.
// - Overtemperature latches off, with hysteresis.
// - Output transitions start blanking; trips ignored meanwhile.
// - Fault flag is active-low open-drain.
// - Disable falling or enable rising clears latches.
// - Undervoltage tri-states and flags, self-recovers.
// - Each trip holds outputs off about 20 us.
`ifndef HBRIDGE_CFG_SVH
`define HBRIDGE_CFG_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_PERIOD_NS 100
`define TOFF_NS 20000
`define TBLANK_NS 16500
`define TOFF_CYC ((`TOFF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TBLANK_CYC ((`TBLANK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TIMER_W 8

// ****************************************************************
// Register map
// ****************************************************************
`define ADDR_W 4
`define OFS_CTRL 4'h0
`define OFS_STATUS 4'h4
`define OFS_MASK 4'h8
`define OFS_STATE 4'hC
`define CTRL_RST 1'h0
`define MASK_RST 5'h0_0
`define EVT_W 5
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### hbridge_pkg.sv
// Types shared by the H-bridge control and fault logic.
`default_nettype none
package hbridge_pkg;

    // Pin levels from the controller side.
    typedef struct packed {
        logic pol_a;
        logic pol_b;
        logic dis;
        logic en;
        logic flag_pin;
    } pins_t;

    // Comparator levels from the analog sense circuits.
    typedef struct packed {
        logic lim_trip;
        logic fold_trip;
        logic short_det;
        logic hot;
        logic overtemp;
        logic below_hyst;
        logic uv;
    } sense_t;

    // Sticky event bits, same layout for status and mask.
    typedef struct packed {
        logic hot_entry;
        logic chop;
        logic uv;
        logic overtemp;
        logic short_ckt;
    } events_t;

    typedef enum logic [1:0] {
        ST_SLEEP,
        ST_HOLD,
        ST_DRIVE,
        ST_CHOP
    } bridge_state_t;

endpackage
`default_nettype wire

// ### hb_interval_timer.sv
// Down-counting interval timer for blanking and constant-off time.
`default_nettype none
`include "hbridge_cfg.svh"
module hb_interval_timer #(
    parameter int W = `TIMER_W
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic start,
    input wire logic [W-1:0] load,
    output logic busy
);
    logic [W-1:0] cnt_q;

    // A restart reloads even while running, so every new event gets the full interval.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= '0;
        end else if (start) begin
            cnt_q <= load;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - W'(1);
        end
    end

    assign busy = (cnt_q != '0);
endmodule // hb_interval_timer
`default_nettype wire

// ### mcu_pin_model.sv
// Controller-side pin model: enable drive and open-drain flag wire.
`default_nettype none
module mcu_pin_model (
    input wire logic en_req,
    input wire logic en_drv,
    output logic en_pin,
    input wire logic flag_out,
    input wire logic flag_oe,
    output logic flag_wire
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************************************
    // Pin resolution
    // ****************************************************************
    // An undriven enable line falls to its pull-down level.
    assign en_pin = en_drv ? en_req : 1'h0;
    // The flag line only sinks; a pull-up gives its idle high.
    assign flag_wire = flag_oe ? flag_out : 1'h1;
endmodule // mcu_pin_model
`default_nettype wire

// ### hbridge_ctrl_checker.sv
// Assertion checker bound to the H-bridge control block.
`default_nettype none
module hbridge_ctrl_checker (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic polarity_in_a,
    input wire logic primary_disable,
    input wire logic enable_or_secondary_disable,
    input wire logic undervoltage,
    input wire logic bridge_out_a,
    input wire logic bridge_out_a_oe,
    input wire logic bridge_out_b_oe,
    input wire logic fault_flag_n_out,
    input wire logic fault_flag_n_oe,
    input wire logic sleep_mode,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************************************
    // Port relations
    // ****************************************************************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    // Three samples cover both sync stages and the output flop.
    a_sleep_quiet: assert property (
        (!enable_or_secondary_disable) [*3] |=> sleep_mode && !bridge_out_a_oe && !fault_flag_n_oe)
        else $error("sleep left bridge or flag on");
    a_disable_flag: assert property (
        (enable_or_secondary_disable && primary_disable) [*3] |=> fault_flag_n_oe && !bridge_out_a_oe)
        else $error("disable not obeyed");
    a_uv_off: assert property (
        (enable_or_secondary_disable && undervoltage) [*3] |=> fault_flag_n_oe && !bridge_out_b_oe)
        else $error("undervoltage not obeyed");
    // After six clean samples only a latch can hold the flag.
    a_latch_hold: assert property (
        (fault_flag_n_oe && enable_or_secondary_disable && !primary_disable && !undervoltage) [*6]
        |=> fault_flag_n_oe && !bridge_out_a_oe)
        else $error("latch released early");
    a_follow_a: assert property (
        bridge_out_a_oe |-> bridge_out_a == $past(polarity_in_a, 3))
        else $error("output a not following input");
    a_sleep_off: assert property (
        sleep_mode |-> !bridge_out_a_oe && !bridge_out_b_oe)
        else $error("sleep with bridge driven");
    a_flag_open_drain: assert property (
        fault_flag_n_out == 1'h0)
        else $error("flag pin driven high");
    a_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
endmodule // hbridge_ctrl_checker

bind hbridge_ctrl hbridge_ctrl_checker chk (
    .ref_clk, .rstn, .polarity_in_a, .primary_disable, .enable_or_secondary_disable,
    .undervoltage, .bridge_out_a, .bridge_out_a_oe, .bridge_out_b_oe, .fault_flag_n_out,
    .fault_flag_n_oe, .sleep_mode, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid
);
`default_nettype wire

// ### hbridge_control_fault_logic_tb_top.sv
// Self-checking testbench of the H-bridge control and fault logic.
`default_nettype none
`include "hbridge_cfg.svh"
module hbridge_control_fault_logic_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk, rstn, polarity_in_a, polarity_in_b, primary_disable, en_req, en_drv;
    logic enable_or_secondary_disable, fault_flag_n_in, limit_trip, foldback_trip;
    logic short_detect, temp_hot, temp_over, temp_below_hyst, undervoltage;
    logic bridge_out_a, bridge_out_a_oe, bridge_out_b, bridge_out_b_oe;
    logic fault_flag_n_out, fault_flag_n_oe, sleep_mode, irq;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    int fails, cmp_count, n, m_latch, m_sw;
    int seed = 32'h51f2_da5c;

    hbridge_ctrl uut (
        .ref_clk, .rstn, .polarity_in_a, .polarity_in_b, .primary_disable,
        .enable_or_secondary_disable, .fault_flag_n_in, .limit_trip, .foldback_trip,
        .short_detect, .temp_hot, .temp_over, .temp_below_hyst, .undervoltage,
        .bridge_out_a, .bridge_out_a_oe, .bridge_out_b, .bridge_out_b_oe,
        .fault_flag_n_out, .fault_flag_n_oe, .sleep_mode, .irq,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready
    );
    mcu_pin_model mcu (.en_req, .en_drv, .en_pin(enable_or_secondary_disable),
        .flag_out(fault_flag_n_out), .flag_oe(fault_flag_n_oe), .flag_wire(fault_flag_n_in));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask
    // Reference model: pin levels plus tracked latch and software disable.
    task automatic settle(input int cyc);
        logic e_oe;
        logic e_fl;
        repeat (cyc) @(posedge ref_clk);
        #1;
        e_oe = enable_or_secondary_disable && !primary_disable && !undervoltage;
        e_oe = e_oe && m_latch == 0 && m_sw == 0;
        e_fl = enable_or_secondary_disable && (primary_disable || undervoltage || m_latch != 0);
        chk({bridge_out_a_oe, bridge_out_b_oe}, {e_oe, e_oe}, "oe");
        chk({fault_flag_n_oe, fault_flag_n_in}, {e_fl, !e_fl}, "flag");
        chk(sleep_mode, !enable_or_secondary_disable, "sleep");
        if (e_oe) chk({bridge_out_a, bridge_out_b}, {polarity_in_a, polarity_in_b}, "levels");
        @(posedge ref_clk);
    endtask
    task automatic wait_oe(input logic lvl, input int max, output int cnt);
        cnt = 0;
        while (bridge_out_a_oe !== lvl && cnt < max) begin
            @(posedge ref_clk);
            cnt++;
        end
    endtask
    task automatic axi_write(input logic [3:0] a, input logic [31:0] v);
        int k;
        k = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        do begin
            @(posedge ref_clk);
            k++;
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1 && k < 100);
        chk({k < 100, s_axi_bresp}, {1'h1, `RESP_OKAY}, "write answer");
    endtask
    task automatic axi_read(input logic [3:0] a);
        int k;
        k = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do begin
            @(posedge ref_clk);
            k++;
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1 && k < 100);
        d = s_axi_rdata;
        r = s_axi_rresp;
        chk(k < 100, 1, "read answer");
    endtask
    task automatic summarize();
        $display("counts: %0d compares, %0d mismatches", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ****************************************************************
    // Stimulus
    // ****************************************************************
    initial begin
        ref_clk = 1'h0;
        forever #50 ref_clk = ~ref_clk;
    end
    // All tests take about 5300 cycles.
    initial begin
        repeat (40000) @(posedge ref_clk);
        fails++;
        $display("mismatch at %0t: watchdog expired", $time);
        summarize();
    end
    initial begin
        {rstn, polarity_in_a, polarity_in_b, primary_disable, en_req, en_drv} = 6'h00;
        {limit_trip, foldback_trip, short_detect, temp_hot, temp_over, undervoltage} = 6'h00;
        {temp_below_hyst, s_axi_bready, s_axi_rready} = 3'h7;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_wstrb} = 7'h0f;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
        {fails, cmp_count, m_latch, m_sw} = 128'h0;
        repeat (6) @(posedge ref_clk);
        rstn <= 1'h1;
        @(posedge ref_clk);
        settle(4);
        axi_read(`OFS_MASK);
        chk(d, 32'h0000_0000, "mask reset");
        axi_read(4'h6);
        chk({r, d}, {`RESP_SLVERR, 32'h0000_0000}, "unmapped");
        $display("test reset done");
        en_drv <= 1'h1;
        en_req <= 1'h1;
        for (int i = 0; i < 8; i++) begin
            {polarity_in_a, polarity_in_b} <= 2'(i < 4 ? i : $random(seed));
            repeat (460) @(posedge ref_clk);
            settle(0);
        end
        $display("test polarity done");
        primary_disable <= 1'h1;
        settle(4);
        primary_disable <= 1'h0;
        settle(4);
        axi_write(`OFS_CTRL, 32'h0000_0001);
        m_sw = 1;
        settle(4);
        axi_write(`OFS_CTRL, 32'h0000_0000);
        m_sw = 0;
        en_req <= 1'h0;
        settle(3);
        en_req <= 1'h1;
        settle(4);
        $display("test disables done");
        repeat (170) @(posedge ref_clk);
        limit_trip <= 1'h1;
        wait_oe(1'h0, 20, n);
        chk(n < 20, 1, "trip");
        wait_oe(1'h1, 400, n);
        chk(n >= 198 && n <= 202, 1, "off time");
        wait_oe(1'h0, 400, n);
        chk(n >= 160 && n <= 170, 1, "blanking");
        wait_oe(1'h1, 400, n);
        chk(n >= 198 && n <= 202, 1, "second off");
        limit_trip <= 1'h0;
        chk(irq, 1'h0, "masked irq");
        axi_write(`OFS_MASK, 32'h0000_0008);
        repeat (3) @(posedge ref_clk);
        chk(irq, 1'h1, "irq raised");
        axi_read(`OFS_STATUS);
        chk(d & 32'h0000_0008, 32'h0000_0008, "chop status");
        repeat (3) @(posedge ref_clk);
        chk(irq, 1'h0, "irq cleared");
        temp_hot <= 1'h1;
        foldback_trip <= 1'h1;
        wait_oe(1'h0, 300, n);
        chk(n < 300, 1, "hot trip");
        foldback_trip <= 1'h0;
        wait_oe(1'h1, 300, n);
        temp_hot <= 1'h0;
        foldback_trip <= 1'h1;
        wait_oe(1'h0, 300, n);
        chk(n, 300, "cool trip ignored");
        foldback_trip <= 1'h0;
        $display("test current limit done");
        for (int i = 0; i < 2; i++) begin
            short_detect <= 1'h1;
            repeat (3) @(posedge ref_clk);
            short_detect <= 1'h0;
            m_latch = 1;
            settle(10);
            if (i == 0) en_req <= 1'h0;
            if (i == 1) primary_disable <= 1'h1;
            repeat (5) @(posedge ref_clk);
            {en_req, primary_disable} <= 2'h2;
            m_latch = 0;
            settle(6);
        end
        temp_below_hyst <= 1'h0;
        temp_over <= 1'h1;
        repeat (4) @(posedge ref_clk);
        temp_over <= 1'h0;
        m_latch = 1;
        settle(10);
        for (int i = 0; i < 2; i++) begin
            // Disable edge clears only below the hysteresis point.
            temp_below_hyst <= 1'(i);
            primary_disable <= 1'h1;
            repeat (5) @(posedge ref_clk);
            primary_disable <= 1'h0;
            m_latch = 1 - i;
            settle(6);
        end
        $display("test latches done");
        undervoltage <= 1'h1;
        settle(4);
        undervoltage <= 1'h0;
        settle(6);
        $display("test undervoltage done");
        summarize();
    end
endmodule // hbridge_control_fault_logic_tb_top
`default_nettype wire
